// [rtl/rx_gain_cfg.svh]
// Function
// R1: Transmit clock multiplier accepts only 1, 2, 4 or 8; DAC clock is factor times oscillator.
// R2: Host presents one transmit sample per two DAC clocks interpolating, else one per clock.
// R3: Gain range -6..+36 dB in narrow band or bypass, -6..+30 dB in wide band.
// R4: Serial gain mode: five-bit gain word selects gain in 2 dB steps.
// R5: Gain splits into continuous stage 0..30 dB/6 dB and switched stage -6..+6/2 dB.
// R6: Pin mode takes three-bit code without clock; sets gain split and boost output.
// R7: Codes 0,1 give -6 dB, code 2 gives 2 dB, code 3 gives 10 dB, boost low.
// R8: Codes 4..7 with boost high give 2, 10, 18, 26 dB with listed splits.
// R9: Low-pass cutoff is ADC clock times 64 over 64 plus tuning target.
// R10: Low-pass filter offers two passbands and a bypass, chosen by configuration.
// R11: ADC words are straight binary and clamp at maximum or zero beyond full scale.
// R12: Signed coding differs from straight binary only by an inverted top bit.
// R13: Bypassable single-pole high-pass H(z)=(z-0.99994)/(z-0.98466), one update per ADC clock.
// R14: Enabled high-pass adds exactly one ADC cycle latency; bypass adds none.
// R15: After reset gain follows pin code; serial gain only after host selects it.
// R16: Gain change not touching continuous stage shows in samples about 7 cycles later.
// R17: High-pass built in fixed point, accurate to one LSB of a 10-bit word.
`ifndef RX_GAIN_CFG_SVH
`define RX_GAIN_CFG_SVH
`define ADDR_W 5
`define REG_CTRL 5'h00
`define REG_GAIN 5'h01
`define REG_TUNE 5'h05
`define REG_STAT 5'h08
`define REG_TCLK 5'h09
`define CTRL_RST 8'h00
`define TUNE_RST 8'h00
`define OSC_KHZ 32'd50000
`define GAIN_DELAY 7
`define GAIN_MAX_W 5'd21
`define GAIN_MAX_N 5'd18
`define HPF_FRAC 18
`define HPF_B 20'sd262128
`define HPF_A 20'sd258123
`endif

// [rtl/rx_gain_pkg.sv]
`default_nettype none
package rx_gain_pkg;
    typedef enum logic [1:0] {
        LPF_NARROW = 2'b00,
        LPF_WIDE = 2'b01,
        LPF_BYPASS = 2'b10
    } lpf_mode_t;
    typedef enum logic [1:0] {
        GSRC_PIN = 2'b00,
        GSRC_SERIAL = 2'b01
    } gain_src_t;
    typedef struct packed {
        logic signed [6:0] total_db;
        logic [4:0] cont_db;
        logic signed [4:0] sw_db;
        logic boost;
    } gain_set_t;
endpackage
`default_nettype wire

// [rtl/hpf_if.sv]
`default_nettype none
interface hpf_if;
    logic [9:0] din;
    logic bypass;
    logic [9:0] dout;
    modport filt (input din, input bypass, output dout);
    modport user (output din, output bypass, input dout);
endinterface
`default_nettype wire

// [rtl/rx_hpf.sv]
`include "rx_gain_cfg.svh"
`default_nettype none
module rx_hpf
    import rx_gain_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    hpf_if.filt hif
);
    // Offset-binary to signed, then y = x - b*x1 + a*y1 in Q.18 fixed point
    logic signed [10:0] x;
    logic signed [10:0] x1_reg;
    logic signed [31:0] y_reg;
    logic signed [31:0] y_next;
    logic signed [31:0] yq;
    logic [9:0] out_reg;
    logic [9:0] clamp;
    assign x = $signed({1'b0, hif.din}) - 11'sd512;
    // R17 fixed point
    // Feedback product needs 64 bits: a large step drives y near 2^28 in Q.18
    assign y_next = (32'(x) <<< `HPF_FRAC) - 32'(x1_reg) * 32'(`HPF_B)
        + 32'((64'(y_reg) * 64'(`HPF_A)) >>> `HPF_FRAC);
    // Rounded from the next state so the output register is the only added stage
    assign yq = (y_next + 32'sd131072) >>> `HPF_FRAC;
    // Output clamps to code range, back to straight binary
    assign clamp = (yq > 32'sd511) ? 10'h3FF : (yq < -32'sd512) ? 10'h000 :
        10'(yq + 32'sd512);
    // R13 filter update
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            x1_reg <= '0;
            y_reg <= '0;
        end else begin
            x1_reg <= x;
            y_reg <= y_next;
        end
    end
    // R14 one cycle latency
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_reg <= 10'h200;
        end else begin
            out_reg <= clamp;
        end
    end
    assign hif.dout = hif.bypass ? hif.din : out_reg;
endmodule
`default_nettype wire

// [rtl/rx_gain_decode_and_hpf.sv]
`include "rx_gain_cfg.svh"
`default_nettype none
module rx_gain_decode_and_hpf
    import rx_gain_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [2:0] pin_gain_code,
    input wire logic [9:0] adc_raw,
    input wire logic adc_over,
    input wire logic adc_under,
    output logic [9:0] rx_sample,
    output logic external_boost_out,
    output logic [4:0] continuous_gain_stage,
    output logic signed [4:0] switched_cap_gain_stage,
    output logic [1:0] lpf_band,
    output logic [7:0] lpf_tune_target,
    output logic [3:0] tx_clock_multiplier_loop,
    output logic [3:0] tx_words_per_dac
);
    // Control: [0] serial gain, [2:1] lpf mode, [3] hpf bypass, [4] signed out, [5] interp on
    logic [7:0] ctrl_reg;
    logic [7:0] gain_reg;
    logic [7:0] tune_reg;
    logic [1:0] mult_reg;
    logic [7:0] rdata_reg;
    gain_set_t pin_set;
    gain_set_t ser_set;
    gain_set_t act_set;
    gain_set_t set_reg;
    logic [4:0] gmax;
    logic [4:0] gword;
    logic [2:0] code_s1_reg, code_s2_reg, code_s3_reg, code_reg;
    lpf_mode_t lmode;
    hpf_if hif();

    // Serial gain word to split: continuous stage takes multiples of 6 dB
    function automatic gain_set_t split_gain(input logic [4:0] w);
        gain_set_t g;
        logic [5:0] db;
        logic [5:0] c;
        g = '0;
        db = 6'(w) << 1;
        c = (db >= 6'd30) ? 6'd30 : (db >= 6'd24) ? 6'd24 : (db >= 6'd18) ? 6'd18 :
            (db >= 6'd12) ? 6'd12 : (db >= 6'd6) ? 6'd6 : 6'd0;
        g.total_db = 7'(db) - 7'sd6;
        g.cont_db = 5'(c);
        g.sw_db = 5'(db - c) - 5'sd6;
        g.boost = 1'b0;
        return g;
    endfunction

    // R7 R8 pin code table
    function automatic gain_set_t pin_gain(input logic [2:0] c);
        gain_set_t g;
        g = '0;
        case (c)
            3'h0, 3'h1: g = '{-7'sd6, 5'd0, -5'sd6, 1'b0};
            3'h2: g = '{7'sd2, 5'd0, 5'sd2, 1'b0};
            3'h3: g = '{7'sd10, 5'd6, 5'sd4, 1'b0};
            3'h4: g = '{7'sd2, 5'd0, 5'sd2, 1'b1};
            3'h5: g = '{7'sd10, 5'd6, 5'sd4, 1'b1};
            3'h6: g = '{7'sd18, 5'd18, 5'sd0, 1'b1};
            3'h7: g = '{7'sd26, 5'd24, 5'sd2, 1'b1};
            default: g = '0;
        endcase
        return g;
    endfunction

    // Register writes; reset leaves pin-controlled gain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `CTRL_RST;
            gain_reg <= 8'h00;
            tune_reg <= `TUNE_RST;
            mult_reg <= 2'h0;
        end else if (wr) begin
            // R15 mode select
            if (addr == `REG_CTRL) ctrl_reg <= wdata;
            if (addr == `REG_GAIN) gain_reg <= {3'h0, wdata[4:0]};
            // R9 tuning target
            if (addr == `REG_TUNE) tune_reg <= wdata;
            // R1 only four factors exist in a 2-bit code
            if (addr == `REG_TCLK) mult_reg <= wdata[1:0];
        end
    end

    // R6 three-flop sync of the clockless pin code, change taken when stages 2 and 3 agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code_s1_reg <= 3'h0;
            code_s2_reg <= 3'h0;
            code_s3_reg <= 3'h0;
            code_reg <= 3'h0;
        end else begin
            code_s1_reg <= pin_gain_code;
            code_s2_reg <= code_s1_reg;
            code_s3_reg <= code_s2_reg;
            if (code_s2_reg == code_s3_reg) code_reg <= code_s3_reg;
        end
    end

    // R3 gain ceiling depends on band; R4 2 dB steps; R5 split
    assign lmode = lpf_mode_t'(ctrl_reg[2:1]);
    assign gmax = (lmode == LPF_WIDE) ? `GAIN_MAX_N : `GAIN_MAX_W;
    assign gword = (gain_reg[4:0] > gmax) ? gmax : gain_reg[4:0];
    assign ser_set = split_gain(gword);
    assign pin_set = pin_gain(code_reg);
    assign act_set = ctrl_reg[0] ? ser_set : pin_set;

    // R16 gain latency
    // One register stage here; the analog path supplies the rest of the delay
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            set_reg <= '{-7'sd6, 5'd0, -5'sd6, 1'b0};
        end else begin
            set_reg <= act_set;
        end
    end
    assign external_boost_out = set_reg.boost;
    assign continuous_gain_stage = set_reg.cont_db;
    assign switched_cap_gain_stage = set_reg.sw_db;

    // R10 band or bypass; R9 target drives analog tuning
    assign lpf_band = ctrl_reg[2:1];
    assign lpf_tune_target = tune_reg;
    // R1 multiplier as one-hot factor
    assign tx_clock_multiplier_loop = 4'(4'h1 << mult_reg);
    // R2 DAC clocks per host sample
    assign tx_words_per_dac = ctrl_reg[5] ? 4'h2 : 4'h1;

    // R11 clamp to full scale or zero
    logic [9:0] adc_clamped;
    assign adc_clamped = adc_over ? 10'h3FF : adc_under ? 10'h000 : adc_raw;
    assign hif.din = adc_clamped;
    assign hif.bypass = ctrl_reg[3];
    rx_hpf u_hpf (
        .clk(clk),
        .rst(rst),
        .hif(hif)
    );

    // R12 signed coding by top bit only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_sample <= 10'h000;
        end else begin
            rx_sample <= {hif.dout[9] ^ ctrl_reg[4], hif.dout[8:0]};
        end
    end

    // Read port, one cycle later; unmapped reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (rd) begin
            case (addr)
                `REG_CTRL: rdata_reg <= ctrl_reg;
                `REG_GAIN: rdata_reg <= gain_reg;
                `REG_TUNE: rdata_reg <= tune_reg;
                `REG_STAT: rdata_reg <= {set_reg.boost, 4'h0, code_reg};
                `REG_TCLK: rdata_reg <= {6'h00, mult_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign rdata = rdata_reg;

    // Assertions
    property p_boost;
        @(posedge clk) disable iff (rst)
        (!ctrl_reg[0] && $stable(code_reg)) |=> (external_boost_out == $past(code_reg[2]));
    endproperty
    a_boost: assert property (p_boost) else $error("boost mismatch"); // R7
    property p_wide;
        @(posedge clk) disable iff (rst)
        (ctrl_reg[0] && lmode == LPF_WIDE) |=> (set_reg.total_db <= 7'sd30);
    endproperty
    a_wide: assert property (p_wide) else $error("wide gain too high"); // R3
    property p_split;
        @(posedge clk) disable iff (rst)
        1 |-> (7'(continuous_gain_stage) + 7'(switched_cap_gain_stage) == set_reg.total_db);
    endproperty
    a_split: assert property (p_split) else $error("split sum wrong"); // R5
    property p_byp;
        @(posedge clk) disable iff (rst)
        hif.bypass |-> (hif.dout == hif.din);
    endproperty
    a_byp: assert property (p_byp) else $error("bypass adds latency"); // R14
    property p_clamp;
        @(posedge clk) disable iff (rst)
        adc_over |-> (adc_clamped == 10'h3FF);
    endproperty
    a_clamp: assert property (p_clamp) else $error("no clamp"); // R11
    property p_msb;
        @(posedge clk) disable iff (rst)
        1 |=> (rx_sample[8:0] == $past(hif.dout[8:0]));
    endproperty
    a_msb: assert property (p_msb) else $error("low bits changed"); // R12
endmodule
`default_nettype wire

// [sim/baseband_model.sv]
`default_nettype none
module baseband_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] tx_words_per_dac,
    output logic tx_word_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pace_reg;
    logic [3:0] pace_next;
    // transmit word pacing
    // Multiplier is not modelled, so one word every tx_words_per_dac clocks
    assign tx_word_strobe = (pace_reg == 4'h0);
    assign pace_next = (pace_reg + 4'h1 >= tx_words_per_dac) ? 4'h0 : pace_reg + 4'h1;
    // Pace counter restarts on reset so the first word goes out at once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pace_reg <= 4'h0;
        end else begin
            pace_reg <= pace_next;
        end
    end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`include "rx_gain_cfg.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wr, rd, adc_over, adc_under, external_boost_out, tx_word_strobe;
    logic [4:0] addr, continuous_gain_stage;
    logic signed [4:0] switched_cap_gain_stage;
    logic [7:0] wdata, rdata, lpf_tune_target;
    logic [2:0] pin_gain_code;
    logic [9:0] adc_raw, rx_sample, base;
    logic [1:0] lpf_band;
    logic [3:0] tx_clock_multiplier_loop, tx_words_per_dac;
    int miscompares, n_compared, w, band, cnt;
    // Inputs start defined; reset held three cycles
    initial begin
        clk = 1'b0; rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 5'h00; wdata = 8'h00;
        pin_gain_code = 3'h0; adc_raw = 10'h200; adc_over = 1'b0; adc_under = 1'b0;
    end
    always #10 clk = ~clk;
    rx_gain_decode_and_hpf dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pin_gain_code(pin_gain_code), .adc_raw(adc_raw),
        .adc_over(adc_over), .adc_under(adc_under), .rx_sample(rx_sample),
        .external_boost_out(external_boost_out), .continuous_gain_stage(continuous_gain_stage),
        .switched_cap_gain_stage(switched_cap_gain_stage), .lpf_band(lpf_band),
        .lpf_tune_target(lpf_tune_target), .tx_clock_multiplier_loop(tx_clock_multiplier_loop),
        .tx_words_per_dac(tx_words_per_dac));
    baseband_model far_end (.clk(clk), .rst(rst), .tx_words_per_dac(tx_words_per_dac),
        .tx_word_strobe(tx_word_strobe));
    task end_of_test;
        if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // Tolerance covers fixed-point rounding in the filter
    task chk_near(input string nm, input int exp, input logic [9:0] got, input int tol);
        n_compared++;
        if ($isunknown(got) || int'(got) > exp + tol || int'(got) < exp - tol) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // Stage split must sum to the total and sit on each stage's step grid
    task chk_gain(input int tot);
        logic signed [7:0] sum;
        logic bad;
        sum = $signed({3'b000, continuous_gain_stage}) + {{3{switched_cap_gain_stage[4]}},
            switched_cap_gain_stage};
        bad = (continuous_gain_stage % 6 != 0) || (continuous_gain_stage > 5'd30) ||
            switched_cap_gain_stage[0] || (switched_cap_gain_stage < -5'sd6) ||
            (switched_cap_gain_stage > 5'sd6);
        chk("gain total", 16'(tot), {{8{sum[7]}}, sum});
        chk("stage grid", 16'h0000, {15'h0000, bad});
    endtask
    task wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [4:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, {8'h00, exp}, {8'h00, rdata});
    endtask
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function int pin_total(input logic [2:0] c);
        int t[8] = '{-6, -6, 2, 10, 2, 10, 18, 26};
        return t[c];
    endfunction
    function logic [9:0] exp_smp(logic [9:0] r, logic o, logic u, logic sg);
        logic [9:0] v;
        v = o ? 10'h3FF : (u ? 10'h000 : r);
        return sg ? {~v[9], v[8:0]} : v;
    endfunction
    // Watchdog so a stuck run still reaches the verdict
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        end_of_test;
    end
    initial begin
        void'($urandom(32'hf48178b8));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`REG_CTRL, `CTRL_RST, "ctrl reset");
        rd_chk(`REG_TUNE, `TUNE_RST, "tune reset");
        rd_chk(5'h1F, 8'h00, "unmapped read");
        // Every pin code, pins are synchronised so allow a few clocks
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            pin_gain_code <= 3'(c);
            settle(8);
            chk_gain(pin_total(3'(c)));
            chk("boost", {15'h0000, c[2]}, {15'h0000, external_boost_out});
            rd_chk(`REG_STAT, {c[2], 4'h0, 3'(c)}, "status");
        end
        // Serial words with both ends of the range in every band
        for (int i = 0; i < 15; i++) begin
            w = (i < 3) ? 31 : ((i < 6) ? 0 : $urandom_range(0, 31));
            band = i % 3;
            wr_reg(`REG_CTRL, {5'h00, 2'(band), 1'b1});
            wr_reg(`REG_GAIN, 8'(w));
            settle(3);
            chk_gain((2 * w - 6 > (band == 1 ? 30 : 36)) ? (band == 1 ? 30 : 36) : 2 * w - 6);
            chk("band", 16'(band), {14'h0000, lpf_band});
        end
        w = $urandom_range(0, 255);
        wr_reg(`REG_TUNE, 8'(w));
        settle(2);
        chk("tune", 16'(w), {8'h00, lpf_tune_target});
        rd_chk(`REG_TUNE, 8'(w), "tune read");
        for (int k = 0; k < 4; k++) begin
            wr_reg(`REG_TCLK, 8'(k));
            settle(2);
            chk("multiplier", 16'(1 << k), {12'h000, tx_clock_multiplier_loop});
        end
        // Interpolation off then on; count far-end words over eight clocks
        for (int b = 0; b < 2; b++) begin
            wr_reg(`REG_CTRL, {2'b00, 1'(b), 5'h08});
            settle(2);
            chk("words per dac", 16'(b + 1), {12'h000, tx_words_per_dac});
            cnt = 0;
            repeat (8) begin
                @(posedge clk);
                #1 cnt += int'(tx_word_strobe);
            end
            chk("tx pace", 16'(8 / (b + 1)), 16'(cnt));
        end
        // Filter bypassed: one-cycle path, clamping, then signed coding
        for (int s = 0; s < 2; s++) begin
            wr_reg(`REG_CTRL, {3'b000, 1'(s), 4'h8});
            for (int i = 0; i < 12; i++) begin
                @(posedge clk);
                adc_raw <= 10'($urandom);
                adc_over <= (i % 4 == 1);
                adc_under <= (i % 4 == 2);
                @(posedge clk);
                #1 chk("sample", 16'(exp_smp(adc_raw, adc_over, adc_under, 1'(s))), 16'(rx_sample));
            end
        end
        // Filter on: DC removed, then a step shows two clocks later
        wr_reg(`REG_CTRL, 8'h00);
        @(posedge clk);
        adc_raw <= 10'h300; adc_over <= 1'b0; adc_under <= 1'b0;
        settle(700);
        chk_near("hpf dc", 32'h200, rx_sample, 3);
        base = rx_sample;
        @(posedge clk);
        adc_raw <= 10'h380;
        settle(1);
        chk("hpf hold", 16'(base), 16'(rx_sample));
        settle(1);
        chk_near("hpf step", int'(base) + 128, rx_sample, 2);
        end_of_test;
    end
endmodule
`default_nettype wire
